// File: rtl/pcd_port_cd_override.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Port C and port D alternate-function override
// ****************************************************************
module pcd_port_cd_override
  import pcd_pkg::*;
(
  input wire logic mclk, // System clock, 20 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [PCD_C_W-1:0] portc_data, // Port C data register
  input wire logic [PCD_C_W-1:0] portc_dir, // Port C direction register
  input wire logic [PCD_C_W-1:0] portc_pad_in, // Port C digital pad levels
  input wire logic [PCD_C_W-1:0] portc_analog_in, // Port C analog path levels
  input wire logic [PCD_D_W-1:0] portd_data, // Port D data register
  input wire logic [PCD_D_W-1:0] portd_dir, // Port D direction register
  input wire logic [PCD_D_W-1:0] portd_pad_in, // Port D digital pad levels
  input wire logic cmp_pos_analog, // Analog level of comparator + pad
  input wire logic cmp_neg_analog, // Analog level of comparator - pad
  input wire logic global_pullup_disable, // Disables port pull-ups, except the reset pad pull-up when used as I/O
  input wire logic reset_pin_disable_fuse, // Reset pad used as I/O
  input wire logic two_wire_enable, // Two-wire interface enabled
  input wire logic twi_clock_drive, // Two-wire clock pull-low request
  input wire logic twi_data_drive, // Two-wire data pull-low request
  input wire logic usart_sync_select, // USART synchronous mode
  input wire logic usart_clock_out, // USART clock to drive out
  input wire logic transmitter_enable, // USART transmitter enabled
  input wire logic transmit_data, // USART serial transmit data
  input wire logic receiver_enable, // USART receiver enabled
  input wire logic ext_irq_zero_enable, // External interrupt 0 enabled
  input wire logic ext_irq_one_enable, // External interrupt 1 enabled
  output logic [PCD_C_W-1:0] portc_pullup, // Port C pull-up enables
  output logic [PCD_C_W-1:0] portc_drive_en, // Port C output driver enables
  output logic [PCD_C_W-1:0] portc_out_value, // Port C output levels
  output logic [PCD_C_W-1:0] portc_input_en, // Port C digital input enables
  output logic [PCD_D_W-1:0] portd_pullup, // Port D pull-up enables
  output logic [PCD_D_W-1:0] portd_drive_en, // Port D output driver enables
  output logic [PCD_D_W-1:0] portd_out_value, // Port D output levels
  output logic [PCD_D_W-1:0] portd_input_en, // Port D digital input enables
  output logic twi_slew_limit, // Slew limit on two-wire pads
  output logic twi_clock_in, // Filtered two-wire clock line
  output logic twi_data_in, // Filtered two-wire data line
  output logic [PCD_ADC_W-1:0] adc_channel_level, // Converter channel levels
  output logic reset_line_level, // Reset input level, active low
  output logic usart_ext_clock_in, // USART external clock input
  output logic timer0_count_source, // Timer 0 external count input
  output logic timer1_count_source, // Timer 1 external count input
  output logic receive_data_in, // USART receive data
  output logic ext_irq_zero_in, // External interrupt 0 level
  output logic ext_irq_one_in, // External interrupt 1 level
  output logic comparator_positive_in, // Comparator + level
  output logic comparator_negative_in, // Comparator - level
  output logic [PCD_C_W-1:0] portc_dir_read, // Port C direction read-back
  output logic [PCD_C_W-1:0] portc_data_read, // Port C data read-back
  output logic [PCD_C_W-1:0] portc_pin_read, // Port C pin read-back
  output logic [PCD_D_W-1:0] portd_pin_read // Port D pin read-back
);

  // ****************************************************************
  // Override sources
  // ****************************************************************
  logic [PCD_C_W-1:0] c_pu_en, c_pu_val, c_dir_en, c_dir_val;
  logic [PCD_C_W-1:0] c_out_en, c_out_val, c_ie_en, c_ie_val;
  logic [PCD_D_W-1:0] d_pu_en, d_pu_val, d_dir_en, d_dir_val;
  logic [PCD_D_W-1:0] d_out_en, d_out_val, d_ie_en, d_ie_val;
  logic twi_pu_c;
  logic twi_pu_d;

  always_comb
  begin
    c_pu_en = '0;
    c_pu_val = '0;
    c_dir_en = '0;
    c_dir_val = '0;
    c_out_en = '0;
    c_out_val = '0;
    c_ie_en = '0;
    c_ie_val = '0;
    d_pu_en = '0;
    d_pu_val = '0;
    d_dir_en = '0;
    d_dir_val = '0;
    d_out_en = '0;
    d_out_val = '0;
    d_ie_en = '0;
    d_ie_val = '0;
    twi_pu_c = portc_data[PCD_PAD_CLOCK] & ~global_pullup_disable;
    twi_pu_d = portc_data[PCD_PAD_DATA] & ~global_pullup_disable;
    // Output value of the reset pad is never overridden
    c_pu_en[PCD_PAD_RESET] = reset_pin_disable_fuse;
    c_pu_val[PCD_PAD_RESET] = 1'h1;
    c_dir_en[PCD_PAD_RESET] = reset_pin_disable_fuse;
    c_ie_en[PCD_PAD_RESET] = reset_pin_disable_fuse;
    c_pu_en[PCD_PAD_CLOCK] = two_wire_enable;
    c_pu_val[PCD_PAD_CLOCK] = twi_pu_c;
    c_pu_en[PCD_PAD_DATA] = two_wire_enable;
    c_pu_val[PCD_PAD_DATA] = twi_pu_d;
    c_dir_en[PCD_PAD_CLOCK] = two_wire_enable;
    c_dir_val[PCD_PAD_CLOCK] = twi_clock_drive;
    c_dir_en[PCD_PAD_DATA] = two_wire_enable;
    c_dir_val[PCD_PAD_DATA] = twi_data_drive;
    // Value held low so the pad only pulls down or floats
    c_out_en[PCD_PAD_CLOCK] = two_wire_enable;
    c_out_en[PCD_PAD_DATA] = two_wire_enable;
    d_out_en[PCD_PAD_UCLK] = usart_sync_select;
    d_out_val[PCD_PAD_UCLK] = usart_clock_out;
    d_pu_en[PCD_PAD_TXD] = transmitter_enable;
    d_dir_en[PCD_PAD_TXD] = transmitter_enable;
    d_dir_val[PCD_PAD_TXD] = 1'h1;
    d_out_en[PCD_PAD_TXD] = transmitter_enable;
    d_out_val[PCD_PAD_TXD] = transmit_data;
    d_pu_en[PCD_PAD_RXD] = receiver_enable;
    d_pu_val[PCD_PAD_RXD] = portd_data[PCD_PAD_RXD] & ~global_pullup_disable;
    d_dir_en[PCD_PAD_RXD] = receiver_enable;
    d_ie_en[PCD_PAD_IRQ0] = ext_irq_zero_enable;
    d_ie_val[PCD_PAD_IRQ0] = 1'h1;
    d_ie_en[PCD_PAD_IRQ1] = ext_irq_one_enable;
    d_ie_val[PCD_PAD_IRQ1] = 1'h1;
  end

  // ****************************************************************
  // Pad control cells
  // ****************************************************************
  logic [PCD_C_W-1:0] c_pu_d, c_dr_d, c_val_d, c_die_d;
  logic [PCD_D_W-1:0] d_pu_d, d_dr_d, d_val_d, d_die_d;

  genvar gi;
  generate
    for (gi = 0; gi < PCD_C_W; gi++)
    begin : g_portc
      pcd_pad_cell u_cell (
        .port_bit(portc_data[gi]),
        .dir_bit(portc_dir[gi]),
        .pu_off(global_pullup_disable),
        .pu_ovr_en(c_pu_en[gi]),
        .pu_ovr_val(c_pu_val[gi]),
        .dir_ovr_en(c_dir_en[gi]),
        .dir_ovr_val(c_dir_val[gi]),
        .out_ovr_en(c_out_en[gi]),
        .out_ovr_val(c_out_val[gi]),
        .ie_ovr_en(c_ie_en[gi]),
        .ie_ovr_val(c_ie_val[gi]),
        .pullup_en(c_pu_d[gi]),
        .drive_en(c_dr_d[gi]),
        .out_value(c_val_d[gi]),
        .input_en(c_die_d[gi])
      );
    end
    for (gi = 0; gi < PCD_D_W; gi++)
    begin : g_portd
      pcd_pad_cell u_cell (
        .port_bit(portd_data[gi]),
        .dir_bit(portd_dir[gi]),
        .pu_off(global_pullup_disable),
        .pu_ovr_en(d_pu_en[gi]),
        .pu_ovr_val(d_pu_val[gi]),
        .dir_ovr_en(d_dir_en[gi]),
        .dir_ovr_val(d_dir_val[gi]),
        .out_ovr_en(d_out_en[gi]),
        .out_ovr_val(d_out_val[gi]),
        .ie_ovr_en(d_ie_en[gi]),
        .ie_ovr_val(d_ie_val[gi]),
        .pullup_en(d_pu_d[gi]),
        .drive_en(d_dr_d[gi]),
        .out_value(d_val_d[gi]),
        .input_en(d_die_d[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Two-wire line filters
  // ****************************************************************
  // Two-wire lines bypass the digital input and use the analog path
  pcd_spike_filter u_filt_clock (
    .mclk(mclk),
    .reset_n(reset_n),
    .raw_level(portc_analog_in[PCD_PAD_CLOCK]),
    .clean_level(twi_clock_in)
  );

  pcd_spike_filter u_filt_data (
    .mclk(mclk),
    .reset_n(reset_n),
    .raw_level(portc_analog_in[PCD_PAD_DATA]),
    .clean_level(twi_data_in)
  );

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  logic [PCD_D_W-1:0] d_pin;
  logic [PCD_C_W-1:0] c_pin;
  logic [PCD_C_W-1:0] c_hide;
  logic reset_mode;

  always_comb
  begin
    reset_mode = ~reset_pin_disable_fuse;
    c_hide = '1;
    c_hide[PCD_PAD_RESET] = ~reset_mode;
    c_pin = portc_pad_in & c_die_d;
    d_pin = portd_pad_in & d_die_d;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      portc_pullup <= '0;
      portc_drive_en <= '0;
      portc_out_value <= '0;
      portc_input_en <= '0;
      portd_pullup <= '0;
      portd_drive_en <= '0;
      portd_out_value <= '0;
      portd_input_en <= '0;
      twi_slew_limit <= PCD_RST_LEVEL;
      adc_channel_level <= '0;
      reset_line_level <= PCD_RST_RESET_LINE;
      usart_ext_clock_in <= PCD_RST_LEVEL;
      timer0_count_source <= PCD_RST_LEVEL;
      timer1_count_source <= PCD_RST_LEVEL;
      receive_data_in <= PCD_RST_LEVEL;
      ext_irq_zero_in <= PCD_RST_LEVEL;
      ext_irq_one_in <= PCD_RST_LEVEL;
      comparator_positive_in <= PCD_RST_LEVEL;
      comparator_negative_in <= PCD_RST_LEVEL;
      portc_dir_read <= '0;
      portc_data_read <= '0;
      portc_pin_read <= '0;
      portd_pin_read <= '0;
    end
    else
    begin
      portc_pullup <= c_pu_d;
      portc_drive_en <= c_dr_d;
      portc_out_value <= c_val_d;
      portc_input_en <= c_die_d;
      portd_pullup <= d_pu_d;
      portd_drive_en <= d_dr_d;
      portd_out_value <= d_val_d;
      portd_input_en <= d_die_d;
      twi_slew_limit <= two_wire_enable;
      adc_channel_level <= portc_analog_in[PCD_ADC_W-1:0];
      // With the fuse programmed the pad no longer resets the part
      reset_line_level <= reset_mode ? portc_analog_in[PCD_PAD_RESET] : 1'h1;
      usart_ext_clock_in <= d_pin[PCD_PAD_UCLK];
      timer0_count_source <= d_pin[PCD_PAD_UCLK];
      timer1_count_source <= d_pin[PCD_PAD_TMR1];
      receive_data_in <= d_pin[PCD_PAD_RXD];
      ext_irq_zero_in <= d_pin[PCD_PAD_IRQ0];
      ext_irq_one_in <= d_pin[PCD_PAD_IRQ1];
      comparator_positive_in <= cmp_pos_analog;
      comparator_negative_in <= cmp_neg_analog;
      portc_dir_read <= portc_dir & c_hide;
      portc_data_read <= portc_data & c_hide;
      portc_pin_read <= c_pin & c_hide;
      portd_pin_read <= d_pin;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_generic_value:
    assert property (!usart_sync_select |=> portd_out_value[4] == $past(portd_data[4]))
    else $error("port value not used without override");

  a_reset_pad_io:
    assert property (reset_pin_disable_fuse |=>
      portc_pullup[6] && !portc_drive_en[6] && !portc_input_en[6]
      && portc_out_value[6] == $past(portc_data[6]))
    else $error("reset pad overrides wrong");

  a_twi_pullup:
    assert property (two_wire_enable |=>
      portc_pullup[5] == $past(portc_data[5] & ~global_pullup_disable))
    else $error("two-wire clock pull-up wrong");

  a_twi_direction:
    assert property (two_wire_enable |=> portc_drive_en[5] == $past(twi_clock_drive)
      && portc_drive_en[4] == $past(twi_data_drive))
    else $error("two-wire direction not from drive signals");

  a_twi_low_only:
    assert property (two_wire_enable |=> !portc_out_value[5] && !portc_out_value[4])
    else $error("two-wire pad drives high");

  a_twi_slew:
    assert property ($rose(two_wire_enable) |=>
      twi_slew_limit ##1 twi_slew_limit == $past(two_wire_enable))
    else $error("slew limit not following enable");

  a_reset_read_zero:
    assert property (!reset_pin_disable_fuse |=>
      !portc_dir_read[6] && !portc_data_read[6] && !portc_pin_read[6])
    else $error("reset pad read-back not zero");

  a_adc_pads_plain:
    assert property (1'h1 |=> portc_drive_en[3:0] == $past(portc_dir[3:0])
      && portc_input_en[3:0] == 4'hF && adc_channel_level[3:0] == $past(portc_analog_in[3:0]))
    else $error("analog-only pad overridden");

  a_xck_drive:
    assert property (usart_sync_select |=> portd_out_value[4] == $past(usart_clock_out))
    else $error("clock pad not driven by USART clock");

  a_xck_fanout:
    assert property (1'h1 |=> usart_ext_clock_in == $past(portd_pad_in[4])
      && timer0_count_source == usart_ext_clock_in)
    else $error("clock pad input not shared");

  a_timer1_route:
    assert property (1'h1 |=> timer1_count_source == $past(portd_pad_in[5])
      && portd_drive_en[5] == $past(portd_dir[5]))
    else $error("timer 1 pad routing wrong");

  a_tx_force:
    assert property (transmitter_enable |=> portd_drive_en[1] && !portd_pullup[1]
      && portd_out_value[1] == $past(transmit_data))
    else $error("transmit pad not forced");

  a_rx_force:
    assert property (receiver_enable |=> !portd_drive_en[0] && receive_data_in == $past(portd_pad_in[0])
      && portd_pullup[0] == $past(portd_data[0] & ~global_pullup_disable))
    else $error("receive pad not forced");

  a_irq_input_on:
    assert property (ext_irq_zero_enable && ext_irq_one_enable |=>
      portd_input_en[2] && portd_input_en[3] && ext_irq_zero_in == $past(portd_pad_in[2]))
    else $error("interrupt pad input not enabled");

  a_comparator:
    assert property (1'h1 |=> comparator_positive_in == $past(cmp_pos_analog)
      && portd_pullup[7] == $past(portd_data[7] & ~portd_dir[7] & ~global_pullup_disable))
    else $error("comparator pad path wrong");

endmodule // pcd_port_cd_override
`default_nettype wire

// File: shared/pcd_pkg.sv
// ****************************************************************
// Port C / port D override constants
// ****************************************************************
package pcd_pkg;

  localparam int PCD_C_W = 7;
  localparam int PCD_D_W = 8;
  localparam int PCD_ADC_W = 6;

  // Port C pad positions
  localparam int PCD_PAD_RESET = 6;
  localparam int PCD_PAD_CLOCK = 5;
  localparam int PCD_PAD_DATA = 4;
  localparam int PCD_ANALOG_ONLY_W = 4;

  // Port D pad positions
  localparam int PCD_PAD_CMP_NEG = 7;
  localparam int PCD_PAD_CMP_POS = 6;
  localparam int PCD_PAD_TMR1 = 5;
  localparam int PCD_PAD_UCLK = 4;
  localparam int PCD_PAD_IRQ1 = 3;
  localparam int PCD_PAD_IRQ0 = 2;
  localparam int PCD_PAD_TXD = 1;
  localparam int PCD_PAD_RXD = 0;

  // Reset values
  localparam logic PCD_RST_LEVEL = 1'h0;
  localparam logic PCD_RST_RESET_LINE = 1'h1;
  localparam logic PCD_DIE_DEFAULT = 1'h1;

  // Spike filter timing: least time, rounded up, at least one cycle
  localparam int PCD_CLK_PERIOD_PS = 50000;
  localparam int PCD_SPIKE_NS = 50;
  localparam int PCD_SPIKE_CYC_RAW = (PCD_SPIKE_NS * 1000 + PCD_CLK_PERIOD_PS - 1)
                                     / PCD_CLK_PERIOD_PS;
  localparam int PCD_SPIKE_CYC = (PCD_SPIKE_CYC_RAW < 1) ? 1 : PCD_SPIKE_CYC_RAW;
  localparam int PCD_SPIKE_CNT_W = 4;

endpackage

// File: rtl/pcd_pad_cell.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Generic pad control with override selection
// ****************************************************************
module pcd_pad_cell
  import pcd_pkg::*;
(
  input wire logic port_bit, // Port data register bit
  input wire logic dir_bit, // Port direction register bit
  input wire logic pu_off, // Global pull-up disable
  input wire logic pu_ovr_en, // Pull-up override enable
  input wire logic pu_ovr_val, // Pull-up override value
  input wire logic dir_ovr_en, // Direction override enable
  input wire logic dir_ovr_val, // Direction override value
  input wire logic out_ovr_en, // Output value override enable
  input wire logic out_ovr_val, // Output value override value
  input wire logic ie_ovr_en, // Input enable override enable
  input wire logic ie_ovr_val, // Input enable override value
  output logic pullup_en, // Resulting pull-up enable
  output logic drive_en, // Resulting output driver enable
  output logic out_value, // Resulting output level
  output logic input_en // Resulting digital input enable
);

  function automatic logic pick(input logic oe, input logic ov, input logic dflt);
    pick = oe ? ov : dflt;
  endfunction

  // Pull-up only while the port leaves the pad an undriven input
  assign pullup_en = pick(pu_ovr_en, pu_ovr_val, port_bit & ~dir_bit & ~pu_off);
  assign drive_en = pick(dir_ovr_en, dir_ovr_val, dir_bit);
  assign out_value = pick(out_ovr_en, out_ovr_val, port_bit);
  assign input_en = pick(ie_ovr_en, ie_ovr_val, PCD_DIE_DEFAULT);

endmodule // pcd_pad_cell
`default_nettype wire

// File: rtl/pcd_spike_filter.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Spike filter for one two-wire line
// ****************************************************************
module pcd_spike_filter
  import pcd_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic raw_level, // Line level from the analog path
  output logic clean_level // Filtered level
);

  logic [PCD_SPIKE_CNT_W-1:0] cnt_q;
  logic [PCD_SPIKE_CNT_W-1:0] cnt_d;
  logic clean_q;
  logic clean_d;
  logic differs;
  localparam logic [PCD_SPIKE_CNT_W-1:0] SPIKE_LIMIT = PCD_SPIKE_CNT_W'(PCD_SPIKE_CYC);

  // A new level must persist past the spike window before it is taken
  always_comb
  begin
    differs = raw_level != clean_q;
    cnt_d = '0;
    clean_d = clean_q;
    if (differs && cnt_q == SPIKE_LIMIT)
    begin
      clean_d = raw_level;
    end
    else if (differs)
    begin
      cnt_d = cnt_q + PCD_SPIKE_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      cnt_q <= '0;
      clean_q <= PCD_RST_LEVEL;
    end
    else
    begin
      cnt_q <= cnt_d;
      clean_q <= clean_d;
    end
  end

  assign clean_level = clean_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Start from a settled cycle, so a level already being taken is no spike
  sequence s_glitch;
    (raw_level == clean_level) ##1 (raw_level != clean_level) ##1 (raw_level == clean_level);
  endsequence

  sequence s_held;
    (raw_level != clean_level) ##1 (raw_level != clean_level && $stable(raw_level));
  endsequence

  a_spike_blocked:
    assert property (s_glitch |=> clean_level == $past(clean_level, 2))
    else $error("one-cycle spike reached the filtered line");

  a_level_passes:
    assert property (s_held |=> clean_level == $past(raw_level))
    else $error("held line level not passed by the filter");

endmodule // pcd_spike_filter
`default_nettype wire

// File: sim/pcd_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// External pins of port D
// ****************************************************************
module pcd_pin_model
(
  input wire logic [7:0] drive_en, // Pad driver enables
  input wire logic [7:0] out_value, // Driven levels
  input wire logic [7:0] pullup_en, // Pull-up enables
  input wire logic [7:0] ext_level, // Outside level on a released pin
  output logic [7:0] pad_level // Resulting pin level
);
  // Released pin shows the pull-up or outside level, never the last driven one
  assign pad_level = (drive_en & out_value) | (~drive_en & (pullup_en | ext_level));
endmodule // pcd_pin_model
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Port C / port D override bench
// ****************************************************************
module tb_top
  import pcd_pkg::*;
;
  logic mclk;
  logic reset_n = 0;
  logic [6:0] portc_data = 0, portc_dir = 0, portc_pad_in = 0, portc_analog_in = 0;
  logic [7:0] portd_data = 0, portd_dir = 0, pd_ext = 0;
  logic cmp_pos_analog = 0, cmp_neg_analog = 0, global_pullup_disable = 0;
  logic reset_pin_disable_fuse = 0, two_wire_enable = 0, twi_clock_drive = 0;
  logic twi_data_drive = 0, usart_sync_select = 0, usart_clock_out = 0;
  logic transmitter_enable = 0, transmit_data = 0, receiver_enable = 0;
  logic ext_irq_zero_enable = 0, ext_irq_one_enable = 0;
  wire [6:0] portc_pullup, portc_drive_en, portc_out_value, portc_input_en;
  wire [6:0] portc_dir_read, portc_data_read, portc_pin_read;
  wire [7:0] portd_pullup, portd_drive_en, portd_out_value, portd_input_en;
  wire [7:0] portd_pin_read, portd_pad_in;
  wire [5:0] adc_channel_level;
  wire twi_slew_limit, twi_clock_in, twi_data_in, reset_line_level, usart_ext_clock_in;
  wire timer0_count_source, timer1_count_source, receive_data_in, ext_irq_zero_in;
  wire ext_irq_one_in, comparator_positive_in, comparator_negative_in;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;

  pcd_port_cd_override i_pcd_port_cd_override (.*);
  pcd_pin_model i_pcd_pin_model (.drive_en(portd_drive_en), .out_value(portd_out_value),
    .pullup_en(portd_pullup), .ext_level(pd_ext), .pad_level(portd_pad_in));

  initial
  begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Whole sequence needs about 26 cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_count++;
      stop_test();
    end
  end

  initial
  begin
    tick(6);
    chk("rst_line", 1, reset_line_level);
    chk("d_drive", 0, portd_drive_en);
    reset_n = 1;
    portd_data = 8'h2A;
    portd_dir = 8'h0F;
    tick(1);
    chk("d_pullup", 8'h20, portd_pullup);
    chk("d_value", 8'h2A, portd_out_value);
    tick(1);
    chk("d_pin", 8'h2A, portd_pin_read);
    chk("t1_src", 1, timer1_count_source);
    pd_ext = 8'h10;
    tick(2);
    chk("t0_src", 1, timer0_count_source);
    chk("xck_in", 1, usart_ext_clock_in);
    portd_data = 8'h2B;
    portd_dir = 8'h01;
    transmitter_enable = 1;
    receiver_enable = 1;
    for (int i = 0; i < 2; i++)
    begin
      transmit_data = i[0];
      tick(1);
      chk("tx_value", 8'h29 | {6'h0, transmit_data, 1'h0}, portd_out_value);
      chk("txrx_drive", 8'h02, portd_drive_en);
      chk("txrx_pullup", 8'h29, portd_pullup);
    end
    chk("rx_in", 1, receive_data_in);
    global_pullup_disable = 1;
    tick(1);
    chk("pud_pullup", 8'h00, portd_pullup);
    usart_sync_select = 1;
    for (int i = 0; i < 2; i++)
    begin
      usart_clock_out = i[0];
      tick(1);
      chk("xck_out", usart_clock_out, portd_out_value[4]);
    end
    global_pullup_disable = 0;
    portc_data = 7'h70;
    portc_dir = 7'h7F;
    two_wire_enable = 1;
    twi_clock_drive = 1;
    reset_pin_disable_fuse = 1;
    tick(1);
    chk("c_pullup", 8'h70, portc_pullup);
    chk("c_drive", 8'h2F, portc_drive_en);
    chk("c_value", 8'h40, portc_out_value);
    chk("c_in_en", 8'h3F, portc_input_en);
    chk("slew", 1, twi_slew_limit);
    two_wire_enable = 0;
    reset_pin_disable_fuse = 0;
    tick(1);
    chk("c_drive_off", 8'h7F, portc_drive_en);
    chk("c_dir_rd", 8'h3F, portc_dir_read);
    chk("c_data_rd", 8'h30, portc_data_read);
    chk("slew_off", 0, twi_slew_limit);
    portc_analog_in = 7'h20;
    tick(1);
    portc_analog_in = 7'h00;
    for (int i = 0; i < 4; i++)
    begin
      tick(1);
      chk("spike", 0, twi_clock_in);
    end
    portc_analog_in = 7'h30;
    tick(1);
    chk("scl_early", 0, twi_clock_in);
    tick(1);
    chk("scl_in", 1, twi_clock_in);
    chk("sda_in", 1, twi_data_in);
    chk("adc", 8'h30, adc_channel_level);
    transmitter_enable = 0;
    receiver_enable = 0;
    usart_sync_select = 0;
    portd_data = 8'h00;
    portd_dir = 8'h00;
    pd_ext = 8'h0C;
    portc_pad_in = 7'h7F;
    ext_irq_zero_enable = 1;
    ext_irq_one_enable = 1;
    cmp_pos_analog = 1;
    cmp_neg_analog = 1;
    tick(2);
    chk("irq0_in", 1, ext_irq_zero_in);
    chk("irq1_in", 1, ext_irq_one_in);
    chk("d_in_en", 8'hFF, portd_input_en);
    chk("c_pin_rd", 8'h3F, portc_pin_read);
    chk("cmp_pos", 1, comparator_positive_in);
    chk("cmp_neg", 1, comparator_negative_in);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
